// *** src/irsmr_pkg.sv ***
// Shared constants and types of the IR sensor measurement read-out block
package irsmr_pkg;
    // ******************************
    // Register map
    // ******************************
    localparam logic [7:0] ADDR_ID0 = 8'h00;
    localparam logic [7:0] ADDR_ID1 = 8'h01;
    localparam logic [7:0] ADDR_INFO0 = 8'h02;
    localparam logic [7:0] ADDR_INFO1 = 8'h03;
    localparam logic [7:0] ADDR_STATA = 8'h04;
    localparam logic [7:0] ADDR_CAUSE = 8'h05;
    localparam logic [7:0] ADDR_IRLO = 8'h06;
    localparam logic [7:0] ADDR_IRHI = 8'h07;
    localparam logic [7:0] ADDR_TMPLO = 8'h08;
    localparam logic [7:0] ADDR_TMPHI = 8'h09;
    localparam logic [7:0] ADDR_STATB = 8'h0A;
    localparam logic [7:0] ADDR_THR0 = 8'h0B;
    localparam logic [7:0] ADDR_THR7 = 8'h12;
    localparam logic [7:0] ADDR_IEN = 8'h13;
    localparam logic [7:0] ADDR_FILT = 8'h14;
    localparam logic [7:0] ADDR_MODE = 8'h15;
    localparam logic [7:0] ADDR_SRST = 8'h16;
    localparam logic [7:0] ADDR_CURRENT = 8'hFF;
    // ******************************
    // Fields and codes
    // ******************************
    localparam int DATA_READY_FLAG_BIT = 0;
    localparam int OVR_BIT = 0;
    localparam int IEN_DATA_READY_FLAG_BIT = 0;
    localparam int CAUSE_DATA_READY_FLAG_BIT = 0;
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_CONT = 2'h1;
    localparam logic [1:0] MODE_SINGLE = 2'h2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ******************************
    // Timing
    // ******************************
    localparam longint MEAS_PERIOD_MS = 100;
    localparam longint NS_PER_MS = 1000000;
    // ******************************
    // Types
    // ******************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrStb;
        logic rdStb;
    } irsmr_bus_req_t;
    typedef struct packed {
        logic [15:0] ir;
        logic [15:0] tmp;
    } irsmr_result_t;
    typedef enum logic [1:0] {TM_IDLE, TM_MEAS, TM_WAIT} irsmr_tstate_t;
endpackage

// *** src/irsmr_readout.sv ***
// Measurement sequencer and read-out register set of the IR sensor
//
// Behaviour
// [R1] Power-on reset loads all initial values and selects standby.
// [R2] Software reset register write returns everything to power-on state.
// [R3] Mode 00 is standby; converter idle, registers stay accessible.
// [R4] Entering standby keeps data and settings, releases the interrupt pin.
// [R5] Mode 01 repeats measurements every 100 ms until standby is written.
// [R6] Each completed measurement updates read-out registers unless protected.
// [R7] Mode change during a measurement aborts it, old results kept.
// [R8] Threshold and interrupt settings stay writable in continuous mode.
// [R9] Mode 10 measures once, stores, then mode returns to 00 itself.
// [R10] Single-shot results bypass the low-pass filter.
// [R11] Storing new data into read-out registers sets data-ready.
// [R12] Enabled data-ready interrupt pulls the pin low as data-ready rises.
// [R13] Starting an interrupt cause read transfers results and freezes them.
// [R14] Reading the interrupt cause register releases the interrupt pin.
// [R15] Host reads status register B after the read-out registers.
// [R16] Status B read ends protection and clears data-ready and overrun.
// [R17] Unread result overtaken by next one keeps data-ready, sets overrun.
// [R18] Data-ready stays set until the host finishes reading.
// [R19] One result during protection is held and copied when read ends.
// [R20] Two results during protection drop the first and set overrun.
// [R21] Reads during a measurement return previous completed results.
// [R22] Host should fetch data only after seeing data-ready set.
// [R23] Address counter wraps status B back to status A, 15H to 0BH.
// [R24] Oscillator tick counter times period and duration, restarts on entry.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module irsmr_readout import irsmr_pkg::*; #(
    parameter longint OSC_PERIOD_NS = 800,
    parameter int PERIOD_TICKS = int'((MEAS_PERIOD_MS * NS_PER_MS) / OSC_PERIOD_NS),
    parameter int MEAS_TICKS = 1250,
    parameter logic [7:0] ID_MAKER = 8'h5A, // Arbitrary value
    parameter logic [7:0] ID_PART = 8'hA5,  // Arbitrary value
    parameter logic [7:0] INFO_A = 8'h00,   // Arbitrary value
    parameter logic [7:0] INFO_B = 8'h00    // Arbitrary value
) (
    input wire logic clk_sys,           // 10 MHz system clock
    input wire logic rst_n,             // Asynchronous reset, active low
    input wire logic oscClk,            // Internal oscillator, asynchronous
    input wire irsmr_bus_req_t regReq,  // Register request
    output logic [7:0] regRdData,       // Read data, cycle after strobe
    input wire irsmr_result_t rawRes,   // Unfiltered converter results
    input wire irsmr_result_t filtRes,  // Filtered converter results
    output logic irqOutLowO,            // Interrupt pin drive level
    output logic irqOutLowOe,           // Interrupt pin pull-down enable
    output logic convActive             // Converter powered and measuring
);
    // ******************************
    // State
    // ******************************
    typedef struct packed {
        logic [1:0] mode;
        logic rdProt;
        logic pending;
        logic dataReadyFlag;
        logic overrunFlag;
        logic irqAct;
        irsmr_result_t buffer;
        irsmr_result_t outRes;
        logic [7:0][7:0] thr;
        logic [7:0] ien;
        logic [7:0] filt;
        logic [7:0] addrCnt;
        logic [7:0] rdData;
        logic conv;
    } irsmr_state_t;

    irsmr_state_t s_r, s_nxt;
    logic rstMeta_r, rstN;
    logic oscRise, measuring, measDone;
    logic [7:0] effAddr;
    logic softRst, modeWr, modeChg, causeRd, statBRd;
    irsmr_result_t res;

    // ******************************
    // Functions
    // ******************************
    function automatic irsmr_state_t resetState();
        irsmr_state_t r;
        r = '0;
        r.mode = MODE_STANDBY;
        r.addrCnt = ADDR_STATA;
        r.thr = {8{RST_BYTE}};
        r.ien = RST_BYTE;
        r.filt = RST_BYTE;
        return r;
    endfunction

    // Burst wrap within the two auto-increment windows
    function automatic logic [7:0] nextAddr(input logic [7:0] a);
        if (a == ADDR_STATB) begin
            return ADDR_STATA;
        end
        if (a == ADDR_MODE) begin
            return ADDR_THR0;
        end
        return a + 8'h01;
    endfunction

    function automatic logic inThr(input logic [7:0] a);
        return (a >= ADDR_THR0) && (a <= ADDR_THR7);
    endfunction

    function automatic logic [7:0] readReg(input irsmr_state_t s, input logic [7:0] a);
        logic [7:0] d;
        d = '0;
        if (inThr(a)) begin
            d = s.thr[3'(a - ADDR_THR0)];
        end else begin
            unique case (a)
                ADDR_ID0: d = ID_MAKER;
                ADDR_ID1: d = ID_PART;
                ADDR_INFO0: d = INFO_A;
                ADDR_INFO1: d = INFO_B;
                ADDR_STATA: d[DATA_READY_FLAG_BIT] = s.dataReadyFlag;
                ADDR_CAUSE: d[CAUSE_DATA_READY_FLAG_BIT] = s.dataReadyFlag;
                ADDR_IRLO: d = s.outRes.ir[7:0];
                ADDR_IRHI: d = s.outRes.ir[15:8];
                ADDR_TMPLO: d = s.outRes.tmp[7:0];
                ADDR_TMPHI: d = s.outRes.tmp[15:8];
                ADDR_STATB: d[OVR_BIT] = s.overrunFlag;
                ADDR_IEN: d = s.ien;
                ADDR_FILT: d = s.filt;
                ADDR_MODE: d = {6'h00, s.mode};
                default: d = '0;
            endcase
        end
        return d;
    endfunction

    // ******************************
    // Reset release
    // ******************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstN <= rstMeta_r;
        end
    end

    // ******************************
    // Oscillator and timer
    // ******************************
    irsmr_sync u_oscSync (
        .clk(clk_sys),
        .rstN(rstN),
        .din(oscClk),
        .rise(oscRise)
    );

    irsmr_timer #(
        .MEAS_TICKS(MEAS_TICKS),
        .PERIOD_TICKS(PERIOD_TICKS)
    ) u_timer (
        .clk(clk_sys),
        .rstN(rstN),
        .tick(oscRise),
        .run(s_r.mode != MODE_STANDBY),
        .restart(modeChg || softRst), // [R2]
        .measuring(measuring),
        .done(measDone)
    ); // [R5] [R24]

    // ******************************
    // Request decode
    // ******************************
    assign effAddr = (regReq.addr == ADDR_CURRENT) ? s_r.addrCnt : regReq.addr;
    assign softRst = regReq.wrStb && (regReq.addr == ADDR_SRST); // [R2]
    assign modeWr = regReq.wrStb && (regReq.addr == ADDR_MODE);
    assign modeChg = modeWr && (regReq.wrData[1:0] != s_r.mode); // [R7]
    assign causeRd = regReq.rdStb && (effAddr == ADDR_CAUSE);
    assign statBRd = regReq.rdStb && (effAddr == ADDR_STATB);
    // Filter only outside single shot
    assign res = (s_r.mode == MODE_SINGLE) ? rawRes : filtRes; // [R10]

    // ******************************
    // Next state
    // ******************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdData = '0;
        s_nxt.conv = measuring && !modeChg;
        // Register reads, side effects first so a same-cycle result wins
        if (regReq.rdStb) begin
            s_nxt.rdData = readReg(s_r, effAddr); // [R21]
            s_nxt.addrCnt = nextAddr(effAddr); // [R23]
        end
        if (causeRd) begin
            s_nxt.outRes = s_r.buffer; // [R13]
            s_nxt.pending = 1'b0;
            s_nxt.rdProt = 1'b1; // [R13]
            s_nxt.irqAct = 1'b0; // [R14]
        end
        if (statBRd) begin
            // Protection ends only here or on a soft reset; the host must issue this read
            s_nxt.rdProt = 1'b0; // [R16]
            s_nxt.overrunFlag = 1'b0; // [R16]
            s_nxt.dataReadyFlag = s_r.pending; // [R16] [R19]
            if (s_r.pending) begin
                s_nxt.outRes = s_r.buffer; // [R19]
            end
            s_nxt.pending = 1'b0;
        end
        // Register writes, accepted in every mode
        if (regReq.wrStb) begin
            if (inThr(regReq.addr)) begin
                s_nxt.thr[3'(regReq.addr - ADDR_THR0)] = regReq.wrData; // [R8]
            end
            if (regReq.addr == ADDR_IEN) begin
                s_nxt.ien = regReq.wrData; // [R8]
            end
            if (regReq.addr == ADDR_FILT) begin
                s_nxt.filt = regReq.wrData;
            end
            if (modeWr) begin
                s_nxt.mode = regReq.wrData[1:0]; // [R3] [R5] [R9]
            end
            s_nxt.addrCnt = nextAddr(regReq.addr);
        end
        // Measurement completion, aborted by a same-cycle mode change
        if (measDone && !modeChg) begin
            s_nxt.buffer = res;
            if (s_nxt.rdProt) begin
                // Earlier held result dropped on a second one
                if (s_nxt.pending) begin
                    s_nxt.overrunFlag = 1'b1; // [R20]
                end
                s_nxt.pending = 1'b1; // [R19]
            end else begin
                s_nxt.outRes = res; // [R6]
                if (s_nxt.dataReadyFlag) begin
                    s_nxt.overrunFlag = 1'b1; // [R17]
                end
                s_nxt.dataReadyFlag = 1'b1; // [R11] [R18]
            end
            if ((s_r.mode == MODE_SINGLE) && !modeWr) begin
                s_nxt.mode = MODE_STANDBY; // [R9]
            end
        end
        // Pin falls with data-ready rise when enabled
        if (!s_r.dataReadyFlag && s_nxt.dataReadyFlag && s_nxt.ien[IEN_DATA_READY_FLAG_BIT]) begin
            s_nxt.irqAct = 1'b1; // [R12]
        end
        // Standby entry keeps data, releases the pin
        if (modeWr && (regReq.wrData[1:0] == MODE_STANDBY)) begin
            s_nxt.irqAct = 1'b0; // [R4]
        end
        if (softRst) begin
            s_nxt = resetState(); // [R2]
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            s_r <= resetState(); // [R1]
        end else begin
            s_r <= s_nxt;
        end
    end

    // ******************************
    // Outputs
    // ******************************
    assign regRdData = s_r.rdData;
    assign irqOutLowO = 1'b0;
    assign irqOutLowOe = s_r.irqAct;
    assign convActive = s_r.conv;

    // ******************************
    // Checks
    // ******************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstN);

    a_soft_reset_state: assert property (softRst |=> (s_r.mode == MODE_STANDBY) // [R2]
        && !s_r.dataReadyFlag && !s_r.rdProt && !irqOutLowOe)
        else $error("soft reset did not restore power-on state");

    a_statb_clears: assert property (statBRd && !measDone && !softRst // [R16]
        |=> !s_r.overrunFlag && !s_r.rdProt)
        else $error("status B read left overrun or protection set");

    a_store_sets_ready: assert property (measDone && !s_r.rdProt && !causeRd // [R11]
        && !modeChg && !softRst |=> s_r.dataReadyFlag && (s_r.outRes == $past(res)))
        else $error("stored result without data-ready");

    a_protect_freeze: assert property (s_r.rdProt && !statBRd && !causeRd && !softRst // [R19]
        |=> $stable(s_r.outRes))
        else $error("read-out registers changed while protected");

    a_irq_on_ready: assert property (measDone && !s_r.rdProt && !s_r.dataReadyFlag // [R12]
        && s_r.ien[IEN_DATA_READY_FLAG_BIT] && !regReq.wrStb && !regReq.rdStb |=> irqOutLowOe)
        else $error("enabled data-ready did not pull interrupt low");

    a_cause_release: assert property (causeRd && !softRst |=> !irqOutLowOe) // [R14]
        else $error("interrupt not released after cause read");

    a_standby_release: assert property (modeWr && (regReq.wrData[1:0] == MODE_STANDBY) // [R4]
        |=> !irqOutLowOe && (s_r.mode == MODE_STANDBY))
        else $error("standby entry kept interrupt low");

    a_single_revert: assert property (measDone && (s_r.mode == MODE_SINGLE) // [R9]
        && !regReq.wrStb |=> (s_r.mode == MODE_STANDBY))
        else $error("single shot mode did not revert to standby");

    a_overrun_skip: assert property (measDone && !s_r.rdProt && s_r.dataReadyFlag // [R17]
        && !regReq.rdStb && !regReq.wrStb |=> s_r.overrunFlag && s_r.dataReadyFlag)
        else $error("skipped result did not set overrun");

    a_double_overrun: assert property (measDone && s_r.rdProt && s_r.pending // [R20]
        && !regReq.rdStb && !regReq.wrStb |=> s_r.overrunFlag && s_r.pending)
        else $error("second protected result did not set overrun");

    a_abort_on_change: assert property (modeChg |=> !measDone ##1 !measDone) // [R7]
        else $error("measurement completed after mode change");

    a_wrap_statb: assert property (regReq.rdStb && !regReq.wrStb // [R23]
        && (effAddr == ADDR_STATB) |=> (s_r.addrCnt == ADDR_STATA))
        else $error("address counter did not wrap to status A");

    a_ready_hold: assert property (s_r.dataReadyFlag && !statBRd && !softRst // [R18]
        |=> s_r.dataReadyFlag)
        else $error("data-ready dropped without status B read");

    a_cause_freeze: assert property (causeRd && !softRst // [R13]
        |=> s_r.rdProt && (s_r.outRes == $past(s_r.buffer)))
        else $error("cause read did not transfer and protect results");

    a_standby_idle: assert property ((s_r.mode == MODE_STANDBY) // [R3]
        && ($past(s_r.mode) == MODE_STANDBY) |=> !convActive)
        else $error("converter active in standby");

    a_rdata_idle: assert property (!regReq.rdStb |=> (regRdData == '0)) // [R3]
        else $error("read data stood longer than one cycle");
endmodule // irsmr_readout

// *** src/irsmr_sync.sv ***
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module irsmr_sync (
    input wire logic clk,  // System clock
    input wire logic rstN, // Synchronised reset
    input wire logic din,  // Asynchronous input
    output logic rise      // One-cycle pulse on filtered rise
);
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic stable;
        logic rise;
    } irsmr_sync_t;
    irsmr_sync_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ff1 = din;
        s_nxt.ff2 = s_r.ff1;
        s_nxt.ff3 = s_r.ff2;
        s_nxt.rise = 1'b0;
        if (s_r.ff2 == s_r.ff3) begin
            s_nxt.stable = s_r.ff3;
            s_nxt.rise = s_r.ff3 && !s_r.stable;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rise = s_r.rise;
endmodule // irsmr_sync

// *** src/irsmr_timer.sv ***
// Measurement period and duration counter driven by oscillator ticks
`timescale 1ns/1ps
module irsmr_timer import irsmr_pkg::*; #(
    parameter int MEAS_TICKS = 1250,
    parameter int PERIOD_TICKS = 125000
) (
    input wire logic clk,     // System clock
    input wire logic rstN,    // Synchronised reset
    input wire logic tick,    // Oscillator tick
    input wire logic run,     // Measuring mode active
    input wire logic restart, // Mode change, abort and restart
    output logic measuring,   // Conversion in progress
    output logic done         // One-cycle completion pulse
);
    typedef struct packed {
        irsmr_tstate_t st;
        logic [23:0] cnt;
        logic done;
    } irsmr_timer_t;
    irsmr_timer_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (restart || !run) begin
            s_nxt.st = TM_IDLE;
            s_nxt.cnt = '0;
        end else begin
            unique case (s_r.st)
                TM_IDLE: begin
                    s_nxt.st = TM_MEAS;
                    s_nxt.cnt = '0;
                end
                TM_MEAS: begin
                    if (tick) begin
                        s_nxt.cnt = s_r.cnt + 24'h000001;
                        if (s_r.cnt == 24'(MEAS_TICKS - 1)) begin
                            s_nxt.done = 1'b1;
                            s_nxt.st = TM_WAIT;
                        end
                    end
                end
                TM_WAIT: begin
                    if (tick) begin
                        s_nxt.cnt = s_r.cnt + 24'h000001;
                        if (s_r.cnt >= 24'(PERIOD_TICKS - 1)) begin
                            s_nxt.st = TM_MEAS;
                            s_nxt.cnt = '0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_r <= '{st: TM_IDLE, cnt: '0, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign measuring = (s_r.st == TM_MEAS);
    assign done = s_r.done;
endmodule // irsmr_timer

// *** verif/irsmr_far_model.sv ***
// Oscillator, converter results and interrupt pull-up around the read-out block
`timescale 1ns/1ps
module irsmr_far_model import irsmr_pkg::*; (
    input wire logic convActive,   // Measurement running
    input wire logic irqOutLowO,   // Pin drive level
    input wire logic irqOutLowOe,  // Pin pull-down enable
    output logic oscClk,           // Free-running oscillator
    output irsmr_result_t rawRes,  // Unfiltered results
    output irsmr_result_t filtRes, // Filtered results
    output logic irqPin,           // Resolved pin level
    output logic [7:0] seq         // Measurements started
);
    // Open drain with pull-up: a released pin reads high
    assign irqPin = irqOutLowOe ? irqOutLowO : 1'h1;
    // Distinct upper bytes tell filtered from raw
    assign rawRes = '{ir: {8'h1A, seq}, tmp: {8'h2B, seq}};
    assign filtRes = '{ir: {8'h3C, seq}, tmp: {8'h4D, seq}};
    initial begin
        oscClk = 1'h0;
        forever #400 oscClk = ~oscClk;
    end
    initial seq = 8'h00;
    // New sample per measurement, so a stale copy is seen
    always @(posedge convActive) seq <= seq + 8'h01;
endmodule // irsmr_far_model

// *** verif/tb.sv ***
// Self-checking bench of the IR sensor measurement read-out block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("unexpected %s: expected %h, seen %h", nm, ex, gt); end end
module tb import irsmr_pkg::*;;
    logic clk_sys;
    logic rst_n;
    irsmr_bus_req_t regReq;
    logic [7:0] regRdData;
    irsmr_result_t rawRes;
    irsmr_result_t filtRes;
    logic oscClk;
    logic irqOutLowO;
    logic irqOutLowOe;
    logic convActive;
    logic irqPin;
    logic [7:0] seq;
    logic [7:0] d;
    logic [7:0] s;
    int num_errors;
    int n_checks;

    irsmr_readout #(.PERIOD_TICKS(20), .MEAS_TICKS(5)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .oscClk(oscClk), .regReq(regReq), .regRdData(regRdData), .rawRes(rawRes),
        .filtRes(filtRes), .irqOutLowO(irqOutLowO), .irqOutLowOe(irqOutLowOe),
        .convActive(convActive));
    irsmr_far_model far (.convActive(convActive), .irqOutLowO(irqOutLowO),
        .irqOutLowOe(irqOutLowOe), .oscClk(oscClk), .rawRes(rawRes), .filtRes(filtRes),
        .irqPin(irqPin), .seq(seq));

    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regReq <= '{addr: a, wrData: v, wrStb: 1'h1, rdStb: 1'h0};
        @(posedge clk_sys);
        regReq.wrStb <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        regReq <= '{addr: a, wrData: 8'h00, wrStb: 1'h0, rdStb: 1'h1};
        @(posedge clk_sys);
        regReq.rdStb <= 1'h0;
        @(negedge clk_sys);
        v = regRdData;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] ex, input string nm);
        rd(a, d);
        `CHK(nm, ex, d)
    endtask
    task automatic pinChk(input logic ex);
        @(negedge clk_sys);
        `CHK("irq pin", ex, irqPin)
    endtask
    // Status polling is harmless: besides the address counter step, only the cause and status B reads have side effects
    task automatic waitDrdy();
        int i;
        d = 8'h00;
        for (i = 0; i < 400 && d[DATA_READY_FLAG_BIT] !== 1'h1; i++) rd(ADDR_STATA, d);
        `CHK("data ready", 1'h1, d[DATA_READY_FLAG_BIT])
    endtask
    task automatic waitConv(input logic v);
        int i;
        for (i = 0; i < 2000 && convActive !== v; i++) @(negedge clk_sys);
        `CHK("converter", v, convActive)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(60000 * 100);
        num_errors++;
        tally_and_finish();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        regReq = '0;
        rst_n = 1'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        pinChk(1'h1);
        rdc(ADDR_MODE, 8'h00, "mode");
        rdc(ADDR_STATA, 8'h00, "status a");
        rdc(ADDR_STATB, 8'h00, "status b");
        rdc(ADDR_IEN, 8'h00, "irq enable");
        rdc(ADDR_THR0, RST_BYTE, "threshold");
        wr(8'h30, 8'hFF);
        rdc(8'h30, 8'h00, "unmapped");
        wr(ADDR_THR0, 8'hC3);
        rdc(ADDR_THR0, 8'hC3, "threshold");
        wr(ADDR_MODE, {6'h00, MODE_STANDBY});
        rdc(ADDR_CURRENT, 8'hC3, "wrapped read");
        $display("test reset_and_access done");

        wr(ADDR_IEN, 8'h01);
        wr(ADDR_MODE, {6'h00, MODE_SINGLE});
        waitDrdy();
        `CHK("data ready", 1'h1, d[DATA_READY_FLAG_BIT])
        pinChk(1'h0);
        rdc(ADDR_MODE, 8'h00, "mode");
        wr(ADDR_MODE, {6'h00, MODE_STANDBY});
        pinChk(1'h1);
        rdc(ADDR_IRLO, seq, "ir lo");
        rdc(ADDR_IRHI, 8'h1A, "ir hi");
        rdc(ADDR_TMPHI, 8'h2B, "tmp hi");
        rdc(ADDR_CAUSE, 8'h01, "cause");
        rdc(ADDR_STATB, 8'h00, "overrun");
        rdc(ADDR_STATA, 8'h00, "data ready");
        $display("test single_shot done");

        wr(ADDR_MODE, {6'h00, MODE_SINGLE});
        waitDrdy();
        wr(ADDR_MODE, {6'h00, MODE_SINGLE});
        waitConv(1'h1);
        waitConv(1'h0);
        repeat (4) @(posedge clk_sys);
        rdc(ADDR_STATA, 8'h01, "data ready");
        rdc(ADDR_CAUSE, 8'h01, "cause");
        pinChk(1'h1);
        rdc(ADDR_IRLO, seq, "ir lo");
        rdc(ADDR_STATB, 8'h01, "overrun");
        rdc(ADDR_STATA, 8'h00, "data ready");
        $display("test skipped_data done");

        wr(ADDR_MODE, {6'h00, MODE_CONT});
        waitDrdy();
        wr(ADDR_THR0, 8'h5A);
        rdc(ADDR_THR0, 8'h5A, "threshold");
        wr(ADDR_FILT, 8'h03);
        rdc(ADDR_FILT, 8'h03, "filter setting");
        rdc(ADDR_CAUSE, 8'h01, "cause");
        s = seq;
        // Two completions while the read is protected
        repeat (2) begin
            waitConv(1'h1);
            waitConv(1'h0);
        end
        repeat (4) @(posedge clk_sys);
        rdc(ADDR_IRLO, s, "ir lo");
        rdc(ADDR_IRHI, 8'h3C, "ir hi");
        rdc(ADDR_STATB, 8'h01, "overrun");
        rdc(ADDR_CURRENT, 8'h01, "wrapped read");
        rdc(ADDR_IRLO, seq, "ir lo");
        rdc(ADDR_STATB, 8'h00, "overrun");
        waitConv(1'h1);
        s = seq;
        rdc(ADDR_IRLO, s - 8'h01, "ir lo");
        wr(ADDR_MODE, {6'h00, MODE_STANDBY});
        repeat (100) @(posedge clk_sys);
        `CHK("converter", 1'h0, convActive)
        rdc(ADDR_STATA, 8'h00, "data ready");
        rdc(ADDR_IRLO, s - 8'h01, "ir lo");
        $display("test continuous done");

        wr(ADDR_MODE, {6'h00, MODE_CONT});
        waitDrdy();
        pinChk(1'h0);
        wr(ADDR_SRST, RST_BYTE);
        pinChk(1'h1);
        rdc(ADDR_MODE, 8'h00, "mode");
        rdc(ADDR_STATA, 8'h00, "data ready");
        rdc(ADDR_THR0, RST_BYTE, "threshold");
        rdc(ADDR_FILT, RST_BYTE, "filter setting");
        rdc(ADDR_IEN, 8'h00, "irq enable");
        $display("test soft_reset done");
        tally_and_finish();
    end
endmodule // tb
